// [inc/pls_map.svh]
// Register map, field positions, reset values and timing for the loop scheduler
// Behaviour
// - Sample period is four BCD digits, 00.05 to 99.99, meaning 50 ms to 99.99 s.
// - A scan calculates only loops whose sample period has elapsed.
// - Loops of two seconds or less get as many calculations per scan as needed.
// - Loops slower than two seconds get at most one calculation per scan.
// - The fast index may step from the first to the last loop within a scan.
// - The slow index advances once per scan at most, only when next slow loop due.
// - Both indices wrap from the highest loop in use back to loop one.
// - One calculation lasts 150 to 350 us, typically 250 us.
// - Formats 12/15-bit unipolar or bipolar and 16-bit unipolar, applied per loop.
// - The loop task of a scan starts only after the ladder task completes.
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH

`define PLS_CLK_NS 10
`define PLS_TICK_NS 10000000
`define PLS_CALC_MIN_US 150
`define PLS_CALC_TYP_US 250
`define PLS_CALC_MAX_US 350
`define PLS_NS_PER_US 1000

`define PLS_LOOP_AREA_BIT 7
`define PLS_SEL_HI 6
`define PLS_SEL_LO 5
`define PLS_OFS_HI 4
`define PLS_OFS_CFG 5'h00
`define PLS_OFS_PERIOD 5'h07
`define PLS_ADDR_CTRL 8'h80
`define PLS_ADDR_STAT 8'h81
`define PLS_ADDR_DUE 8'h82
`define PLS_ADDR_INVAL 8'h83

`define PLS_PERIOD_RST 16'h0000
`define PLS_CFG_RST 4'h0
`define PLS_CFG_EN_BIT 3
`define PLS_CFG_FMT_HI 2
`define PLS_CTRL_EN_BIT 0
`define PLS_CTRL_MAX_HI 6
`define PLS_CTRL_MAX_LO 4
`define PLS_STAT_SLOW_LO 4
`define PLS_STAT_BUSY_BIT 8
`define PLS_STAT_OVR_BIT 9

`define PLS_PERIOD_MIN 14'h0005
`define PLS_FAST_LIMIT 14'h00C8
`define PLS_ELAPSED_SAT 14'h3FFF
`define PLS_BCD_MAX_DIGIT 4'h9

`define PLS_FMT_U12 3'h0
`define PLS_FMT_B12 3'h1
`define PLS_FMT_U15 3'h2
`define PLS_FMT_B15 3'h3
`define PLS_FMT_U16 3'h4

`endif

// [inc/pls_pkg.sv]
// Types shared by the loop scheduler files
package pls_pkg;
	typedef logic [2:0] pls_idx_t;
	typedef logic [2:0] pls_fmt_t;

	typedef struct packed {
		logic valid;
		pls_idx_t loop;
		pls_fmt_t fmt;
	} pls_calc_s;

	typedef enum logic [2:0] {
		PLS_IDLE,
		PLS_FAST,
		PLS_SLOW,
		PLS_WAIT,
		PLS_DONE
	} pls_state_e;
endpackage : pls_pkg

// [hdl/pls_calc_timer.sv]
// Calculation slot timer: bounds one loop calculation between least and most time
`timescale 1ns/1ns
module pls_calc_timer #(
	parameter int MIN_CYC = 15000,
	parameter int MAX_CYC = 35000
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic start,
	input wire logic done_in,
	output logic busy,
	output logic finish,
	output logic overrun
);
	localparam int CW = $clog2(MAX_CYC + 1);

	logic [CW-1:0] cnt_ff;
	logic busy_ff;
	logic seen_ff;
	logic finish_ff;
	logic overrun_ff;

	// Engine may report done early; the slot still lasts the least time
	wire min_met = cnt_ff >= CW'(MIN_CYC - 1);
	wire at_max = cnt_ff == CW'(MAX_CYC - 1);
	wire got_done = done_in | seen_ff;
	wire end_now = busy_ff & ((got_done & min_met) | at_max);
	wire [CW-1:0] nxt_cnt = cnt_ff + CW'(1);

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			seen_ff <= 1'b0;
			finish_ff <= 1'b0;
			overrun_ff <= 1'b0;
		end else begin
			finish_ff <= end_now & ~start;
			overrun_ff <= end_now & ~start & ~got_done;
			if (start) begin
				cnt_ff <= '0;
				busy_ff <= 1'b1;
				seen_ff <= 1'b0;
			end else if (end_now) begin
				busy_ff <= 1'b0;
			end else if (busy_ff) begin
				cnt_ff <= nxt_cnt;
				seen_ff <= got_done;
			end
		end
	end

	assign busy = busy_ff;
	assign finish = finish_ff;
	assign overrun = overrun_ff;
endmodule : pls_calc_timer

// [hdl/pls_scheduler.sv]
// Loop scheduler: per-loop period timers, fast and slow round-robin indices
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`include "pls_map.svh"
module pls_scheduler #(
	parameter int NUM_LOOPS = 4,
	parameter int TICK_CYC = `PLS_TICK_NS / `PLS_CLK_NS,
	parameter int CALC_MIN_CYC =
		(`PLS_CALC_MIN_US * `PLS_NS_PER_US + `PLS_CLK_NS - 1) / `PLS_CLK_NS,
	parameter int CALC_MAX_CYC =
		(`PLS_CALC_MAX_US * `PLS_NS_PER_US) / `PLS_CLK_NS
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata,
	input wire logic ladder_done,
	input wire logic calc_done,
	output pls_pkg::pls_calc_s calc_req,
	output logic loops_done
);
	import pls_pkg::*;

	localparam int TW = $clog2(TICK_CYC + 1);

	// BCD word to a count of 10 ms units; digits are checked separately
	function automatic logic [13:0] pls_bcd_to_bin(input logic [15:0] bcd);
		logic [13:0] acc;
		acc = 14'(bcd[15:12]) * 14'h03E8;
		acc = acc + 14'(bcd[11:8]) * 14'h0064;
		acc = acc + 14'(bcd[7:4]) * 14'h000A;
		acc = acc + 14'(bcd[3:0]);
		return acc;
	endfunction : pls_bcd_to_bin

	function automatic logic pls_bcd_ok(input logic [15:0] bcd);
		logic ok;
		ok = 1'b1;
		for (int d = 0; d < 4; d++) begin
			if (bcd[d*4 +: 4] > `PLS_BCD_MAX_DIGIT) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : pls_bcd_ok

	logic [15:0] period_ff [NUM_LOOPS];
	logic [3:0] cfg_ff [NUM_LOOPS];
	logic [13:0] elapsed_ff [NUM_LOOPS];
	logic [NUM_LOOPS-1:0] loop_valid;
	logic [NUM_LOOPS-1:0] loop_fast;
	logic [NUM_LOOPS-1:0] loop_due;

	logic [TW-1:0] tick_cnt_ff;
	logic tick_ff;
	logic sched_en_ff;
	pls_idx_t max_loop_ff;
	logic overrun_ff;
	logic [15:0] rdata_ff;

	pls_state_e state_ff;
	pls_state_e nxt_state;
	pls_idx_t ptr_ff;
	pls_idx_t nxt_ptr;
	pls_idx_t steps_ff;
	pls_idx_t nxt_steps;
	pls_idx_t fast_idx_ff;
	pls_idx_t nxt_fast_idx;
	pls_idx_t slow_idx_ff;
	pls_idx_t nxt_slow_idx;
	logic from_slow_ff;
	logic nxt_from_slow;
	logic start_calc;
	pls_calc_s calc_req_ff;
	logic loops_done_ff;

	logic calc_busy;
	logic calc_finish;
	logic calc_overrun;

	// Register decode
	wire in_loop_area = ~reg_addr[`PLS_LOOP_AREA_BIT];
	wire [1:0] sel_loop = reg_addr[`PLS_SEL_HI:`PLS_SEL_LO];
	wire [4:0] sel_ofs = reg_addr[`PLS_OFS_HI:0];
	wire sel_ok = in_loop_area & (32'(sel_loop) < NUM_LOOPS);
	wire hit_period = sel_ok & (sel_ofs == `PLS_OFS_PERIOD);
	wire hit_cfg = sel_ok & (sel_ofs == `PLS_OFS_CFG);
	wire hit_ctrl = reg_addr == `PLS_ADDR_CTRL;
	wire hit_stat = reg_addr == `PLS_ADDR_STAT;
	wire hit_due = reg_addr == `PLS_ADDR_DUE;
	wire hit_inval = reg_addr == `PLS_ADDR_INVAL;
	wire wr_ctrl = reg_we & hit_ctrl;
	wire clr_overrun = reg_we & hit_stat & reg_wdata[`PLS_STAT_OVR_BIT];

	// Out-of-range or zero highest-loop setting falls back to all loops
	wire max_bad = (max_loop_ff == '0) | (32'(max_loop_ff) > NUM_LOOPS);
	wire [2:0] eff_max = max_bad ? 3'(NUM_LOOPS) : max_loop_ff;
	wire [1:0] ptr_loop = 2'(ptr_ff - 3'h1);
	wire [2:0] ptr_next = (ptr_ff >= eff_max) ? 3'h1 : ptr_ff + 3'h1;
	wire [2:0] slow_next =
		(slow_idx_ff >= eff_max) ? 3'h1 : slow_idx_ff + 3'h1;
	wire ptr_en = cfg_ff[ptr_loop][`PLS_CFG_EN_BIT];
	wire ptr_is_fast = loop_valid[ptr_loop] & loop_fast[ptr_loop] & ptr_en;
	wire ptr_is_slow = loop_valid[ptr_loop] & ~loop_fast[ptr_loop] & ptr_en;
	wire ptr_due = loop_due[ptr_loop];

	wire tick_wrap = tick_cnt_ff == TW'(TICK_CYC - 1);
	wire [TW-1:0] tick_inc = tick_cnt_ff + TW'(1);

	genvar k;
	generate
		for (k = 0; k < NUM_LOOPS; k++) begin : g_loop
			wire [13:0] period_bin = pls_bcd_to_bin(period_ff[k]);
			wire sel_me = sel_loop == 2'(k);
			wire wr_period = reg_we & hit_period & sel_me;
			wire wr_cfg = reg_we & hit_cfg & sel_me;
			wire fmt_ok = cfg_ff[k][`PLS_CFG_FMT_HI:0] <= `PLS_FMT_U16;
			wire restart = calc_finish & (calc_req_ff.loop == 3'(k + 1));
			wire sat = elapsed_ff[k] == `PLS_ELAPSED_SAT;
			wire [13:0] elapsed_inc = elapsed_ff[k] + 14'h0001;
			// A tick landing on the restart cycle is counted, not lost
			wire [13:0] nxt_elapsed = restart ? {13'h0000, tick_ff} :
				(tick_ff & ~sat) ? elapsed_inc : elapsed_ff[k];
			assign loop_valid[k] = pls_bcd_ok(period_ff[k]) & fmt_ok &
				(period_bin >= `PLS_PERIOD_MIN);
			assign loop_fast[k] = period_bin <= `PLS_FAST_LIMIT;
			assign loop_due[k] = loop_valid[k] &
				(elapsed_ff[k] >= period_bin);
			always_ff @(posedge clock) begin
				if (srst) begin
					period_ff[k] <= `PLS_PERIOD_RST;
					cfg_ff[k] <= `PLS_CFG_RST;
					elapsed_ff[k] <= '0;
				end else begin
					if (wr_period) begin
						period_ff[k] <= reg_wdata;
					end
					if (wr_cfg) begin
						cfg_ff[k] <= reg_wdata[3:0];
					end
					elapsed_ff[k] <= nxt_elapsed;
				end
			end
		end
	endgenerate

	// Read path
	wire [15:0] rd_loop = hit_period ? period_ff[sel_loop] :
		hit_cfg ? {12'h000, cfg_ff[sel_loop]} : 16'h0000;
	wire [15:0] rd_ctrl = {9'h000, max_loop_ff, 3'h0, sched_en_ff};
	wire [15:0] rd_stat = {6'h00, overrun_ff, calc_busy,
		1'b0, slow_idx_ff, 1'b0, fast_idx_ff};
	wire [15:0] rd_due = 16'(loop_due);
	// Invert at loop width first so unused upper bits read as zero
	wire [NUM_LOOPS-1:0] inval_map = ~loop_valid;
	wire [15:0] rd_inval = 16'(inval_map);
	wire [15:0] rd_word = hit_ctrl ? rd_ctrl : hit_stat ? rd_stat :
		hit_due ? rd_due : hit_inval ? rd_inval : rd_loop;

	always_ff @(posedge clock) begin
		if (srst) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			tick_cnt_ff <= tick_wrap ? '0 : tick_inc;
			tick_ff <= tick_wrap;
			rdata_ff <= reg_re ? rd_word : 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sched_en_ff <= 1'b0;
			// All loops in use until software narrows the range
			max_loop_ff <= 3'(NUM_LOOPS);
			overrun_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				sched_en_ff <= reg_wdata[`PLS_CTRL_EN_BIT];
				max_loop_ff <= reg_wdata[`PLS_CTRL_MAX_HI:`PLS_CTRL_MAX_LO];
			end
			// Set wins over a clear in the same cycle
			overrun_ff <= calc_overrun | (overrun_ff & ~clr_overrun);
		end
	end

	// Scan sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_ptr = ptr_ff;
		nxt_steps = steps_ff;
		nxt_fast_idx = fast_idx_ff;
		nxt_slow_idx = slow_idx_ff;
		nxt_from_slow = from_slow_ff;
		start_calc = 1'b0;
		case (state_ff)
			PLS_IDLE: begin
				if (ladder_done & sched_en_ff) begin
					nxt_state = PLS_FAST;
					nxt_ptr = 3'h1;
				end
			end
			PLS_FAST: begin
				if (ptr_is_fast & ptr_due) begin
					start_calc = 1'b1;
					nxt_from_slow = 1'b0;
					nxt_fast_idx = ptr_ff;
					nxt_state = PLS_WAIT;
				end else if (ptr_ff >= eff_max) begin
					nxt_state = PLS_SLOW;
					nxt_ptr = slow_next;
					nxt_steps = 3'h1;
				end else begin
					nxt_ptr = ptr_next;
				end
			end
			PLS_SLOW: begin
				// Index holds until its next loop is due, so none is skipped
				if (ptr_is_slow) begin
					if (ptr_due) begin
						start_calc = 1'b1;
						nxt_from_slow = 1'b1;
						nxt_slow_idx = ptr_ff;
						nxt_state = PLS_WAIT;
					end else begin
						nxt_state = PLS_DONE;
					end
				end else if (steps_ff >= eff_max) begin
					nxt_state = PLS_DONE;
				end else begin
					nxt_ptr = ptr_next;
					nxt_steps = steps_ff + 3'h1;
				end
			end
			PLS_WAIT: begin
				if (calc_finish) begin
					if (from_slow_ff) begin
						nxt_state = PLS_DONE;
					end else if (ptr_ff >= eff_max) begin
						nxt_state = PLS_SLOW;
						nxt_ptr = slow_next;
						nxt_steps = 3'h1;
					end else begin
						nxt_state = PLS_FAST;
						nxt_ptr = ptr_next;
					end
				end
			end
			PLS_DONE: begin
				nxt_state = PLS_IDLE;
			end
			default: begin
				nxt_state = PLS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= PLS_IDLE;
			ptr_ff <= 3'h1;
			steps_ff <= 3'h1;
			fast_idx_ff <= 3'h0;
			slow_idx_ff <= 3'h0;
			from_slow_ff <= 1'b0;
			calc_req_ff <= '0;
			loops_done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ptr_ff <= nxt_ptr;
			steps_ff <= nxt_steps;
			fast_idx_ff <= nxt_fast_idx;
			slow_idx_ff <= nxt_slow_idx;
			from_slow_ff <= nxt_from_slow;
			calc_req_ff.valid <= start_calc;
			if (start_calc) begin
				calc_req_ff.loop <= ptr_ff;
				calc_req_ff.fmt <= cfg_ff[ptr_loop][`PLS_CFG_FMT_HI:0];
			end
			loops_done_ff <= state_ff == PLS_DONE;
		end
	end

	pls_calc_timer #(
		.MIN_CYC(CALC_MIN_CYC),
		.MAX_CYC(CALC_MAX_CYC)
	) u_calc_timer (
		.clock(clock),
		.srst(srst),
		.start(calc_req_ff.valid),
		.done_in(calc_done),
		.busy(calc_busy),
		.finish(calc_finish),
		.overrun(calc_overrun)
	);

	assign reg_rdata = rdata_ff;
	assign calc_req = calc_req_ff;
	assign loops_done = loops_done_ff;
endmodule : pls_scheduler

// [sim/pls_scheduler_asserts.sv]
// Port assertions for the loop scheduler
`timescale 1ns/1ns
module pls_scheduler_asserts
	import pls_pkg::*;
#(
	parameter int NUM_LOOPS = 4,
	parameter int CALC_MAX_CYC = 35000
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [15:0] reg_rdata,
	input wire logic ladder_done,
	input wire logic calc_done,
	input wire pls_pkg::pls_calc_s calc_req,
	input wire logic loops_done
);
	// Longest forced slot plus a full walk of both phases
	localparam int SLOT_BND = CALC_MAX_CYC + 8 * NUM_LOOPS + 8;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	property p_rd_idle;
		!reg_re |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	logic slot_arm_ff;
	int slot_cnt_ff;
	// Cycles since the last start with neither a new start nor a task end
	always_ff @(posedge clock) begin
		if (srst || loops_done) begin
			slot_arm_ff <= 1'b0;
			slot_cnt_ff <= 0;
		end else if (calc_req.valid) begin
			slot_arm_ff <= 1'b1;
			slot_cnt_ff <= 0;
		end else if (slot_arm_ff) begin
			slot_cnt_ff <= slot_cnt_ff + 1;
		end
	end
	property p_wr_rd;
		reg_we && !reg_addr[7] && reg_addr[4:0] == 5'h07 ##1 !reg_we
			##1 reg_re && reg_addr == $past(reg_addr, 2)
			|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("period word not read back");
	property p_req_gap;
		calc_req.valid |=> !calc_req.valid [*4];
	endproperty
	a_req_gap: assert property (p_req_gap)
		else $error("calculation started too soon");
	property p_done_pulse;
		loops_done |=> !loops_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("loop task end not a pulse");
	property p_req_loop;
		calc_req.valid |-> calc_req.loop >= 3'h1 && calc_req.loop <= NUM_LOOPS;
	endproperty
	a_req_loop: assert property (p_req_loop)
		else $error("loop number out of range");
	property p_req_fmt;
		calc_req.valid |-> calc_req.fmt <= 3'h4;
	endproperty
	a_req_fmt: assert property (p_req_fmt)
		else $error("format code out of range");
	property p_hold;
		!calc_req.valid |-> $stable({calc_req.loop, calc_req.fmt});
	endproperty
	a_hold: assert property (p_hold)
		else $error("loop or format moved between starts");
	property p_excl;
		calc_req.valid |-> !loops_done;
	endproperty
	a_excl: assert property (p_excl)
		else $error("task ended while starting a calculation");
	property p_slot;
		slot_arm_ff |-> slot_cnt_ff < SLOT_BND;
	endproperty
	a_slot: assert property (p_slot)
		else $error("calculation slot never ended");
	c_req: cover property (calc_req.valid);
	c_done: cover property (loops_done);
	c_two: cover property (calc_req.valid ##[1:64] calc_req.valid);
endmodule : pls_scheduler_asserts

bind pls_scheduler pls_scheduler_asserts #(
	.NUM_LOOPS(NUM_LOOPS),
	.CALC_MAX_CYC(CALC_MAX_CYC)
) u_asserts (
	.clock(clock),
	.srst(srst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_we(reg_we),
	.reg_re(reg_re),
	.reg_rdata(reg_rdata),
	.ladder_done(ladder_done),
	.calc_done(calc_done),
	.calc_req(calc_req),
	.loops_done(loops_done)
);

// [sim/testbench.sv]
// Self-checking bench for the loop scheduler
`timescale 1ns/1ns
module testbench;
	import pls_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic ladder_done = 1'b0;
	logic calc_done = 1'b0;
	logic [15:0] reg_rdata;
	pls_calc_s calc_req;
	logic loops_done;
	int error_cnt = 0;
	int checks = 0;
	int cnt [8] = '{default: 0};
	logic [2:0] fexp [8];
	int dly = 0;
	bit moved = 1'b0;

	always #5 clock = ~clock;

	// Short tick and slot counts keep the run to a few thousand cycles
	pls_scheduler #(
		.NUM_LOOPS(4),
		.TICK_CYC(20),
		.CALC_MIN_CYC(5),
		.CALC_MAX_CYC(12)
	) dut (
		.clock(clock),
		.srst(srst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_we(reg_we),
		.reg_re(reg_re),
		.reg_rdata(reg_rdata),
		.ladder_done(ladder_done),
		.calc_done(calc_done),
		.calc_req(calc_req),
		.loops_done(loops_done)
	);

	task tally_and_finish;
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clock);
		reg_we <= 1'b0;
	endtask : wr

	task rc(input logic [7:0] a, input logic [15:0] exp, input string nm,
		input logic [15:0] m = 16'hFFFF);
		@(posedge clock);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clock);
		reg_re <= 1'b0;
		#1 chk(nm, reg_rdata & m, exp);
	endtask : rc

	// One scan: ladder end, then answer each start about six cycles later
	task scan(input bit ack, input bit exp_end);
		int n;
		int slow;
		int last;
		slow = 0;
		last = 0;
		@(posedge clock);
		ladder_done <= 1'b1;
		@(posedge clock);
		ladder_done <= 1'b0;
		for (n = 0; n < 400; n++) begin
			@(posedge clock);
			calc_done <= ack && dly == 1;
			if (dly > 0) dly--;
			#1;
			if (loops_done === 1'b1) break;
			if (calc_req.valid === 1'b1) begin
				chk("fmt", 16'(calc_req.fmt), 16'(fexp[calc_req.loop]));
				chk("order", 16'(calc_req.loop > last), 16'h0001);
				cnt[calc_req.loop]++;
				if (calc_req.loop >= 3) slow++;
				last = calc_req.loop;
				dly = 6;
			end
		end
		chk("scan_end", 16'(n < 400), 16'(exp_end));
		chk("slow_per_scan", 16'(slow > 1), 16'h0000);
	endtask : scan

	initial begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		rc(8'h07, 16'h0000, "period_rst");
		rc(8'h83, 16'h000F, "inval_rst");
		rc(8'h84, 16'h0000, "unmapped");
		wr(8'h07, 16'h0005);
		wr(8'h47, 16'h0201);
		wr(8'h67, 16'h0004);
		wr(8'h27, 16'h00A0);
		rc(8'h27, 16'h00A0, "period_rw");
		rc(8'h83, 16'h000A, "inval_bcd");
		wr(8'h27, 16'h0200);
		wr(8'h67, 16'h0300);
		rc(8'h83, 16'h0000, "inval_ok");
		fexp = '{3'h0, 3'h0, 3'h2, 3'h4, 3'h1, 3'h0, 3'h0, 3'h0};
		for (int i = 1; i < 5; i++) wr(8'((i - 1) * 32), {12'h001, 1'b1, fexp[i]});
		scan(1'b1, 1'b0);
		rc(8'h82, 16'h0001, "due_map");
		wr(8'h80, 16'h0001);
		rc(8'h80, 16'h0001, "ctrl_rw");
		while ($time < 75000) begin
			if (!moved && $time > 40000) begin
				wr(8'h00, 16'h000B);
				fexp[1] = 3'h3;
				moved = 1'b1;
			end
			scan(1'b1, 1'b1);
		end
		chk("loop1_runs", 16'(cnt[1] >= 40 && cnt[1] <= 75), 16'h0001);
		chk("loop2_runs", 16'(cnt[2]), 16'h0001);
		chk("loop3_runs", 16'(cnt[3]), 16'h0001);
		chk("loop4_runs", 16'(cnt[4]), 16'h0001);
		repeat (150) @(posedge clock);
		scan(1'b0, 1'b1);
		rc(8'h81, 16'h0200, "overrun", 16'h0200);
		wr(8'h81, 16'h0200);
		rc(8'h81, 16'h0000, "ovr_clr", 16'h0200);
		rc(8'h81, 16'h0041, "indices", 16'h0077);
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		tally_and_finish();
	end
endmodule : testbench
